// ### bench/macgc_phy_model.sv
module macgc_phy_model
   import macgc_pkg::*;
(
   // Clock and commands.
   input  wire logic                     ref_clk_in,
   input  wire logic                     link_up_in,
   // Pins.
   input  wire macgc_pkg::macgc_nibble_t phy_tx_in,
   output macgc_pkg::macgc_nibble_t      phy_rx_out,
   output logic                          endec_link_out
);
   logic [3:0] pat_q = 4'h5;
   // Idle receive data toggles so a stale nibble never looks valid.
   always @(posedge ref_clk_in) pat_q <= ~pat_q;
   assign phy_rx_out     = '{en: 1'b0, d: pat_q};
   assign endec_link_out = link_up_in;
endmodule

// ### bench/macgc_top_chk.sv
module macgc_top_chk
   import macgc_pkg::*;
(
   input wire logic                      ref_clk_in,
   input wire logic                      sys_rst_in,
   input wire macgc_pkg::macgc_bus_req_t bus_req_in,
   input wire logic                      rx_busy_in,
   input wire logic                      missed_wrap_in,
   input wire logic                      da_valid_in,
   input wire logic [47:0]               da_in,
   input wire macgc_pkg::macgc_nibble_t  phy_tx_out,
   input wire logic                      tx_run_out,
   input wire logic                      rx_run_out,
   input wire logic                      tx_start_ok_out,
   input wire logic                      mac_sw_reset_out,
   input wire logic                      missed_wrap_irq_out,
   input wire logic                      accept_out,
   input wire logic                      accept_valid_out,
   input wire logic                      endec_select_out,
   input wire logic                      mii_select_out,
   input wire logic                      endec_loop_out,
   input wire logic                      mdc_enable_out
);
   logic [15:0] ctl_s;
   logic [4:0]  flt_s;
   logic        go;
   // Shadow of the control registers as software last wrote them.
   assign go = bus_req_in.wr && !mac_sw_reset_out;
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctl_s <= 16'h0000;
         flt_s <= 5'h00;
      end else if (go && bus_req_in.addr == OFS_GLOBAL_CTRL) begin
         ctl_s <= bus_req_in.wdata[GC_SOFT_RESET] ? 16'h0000
                  : bus_req_in.wdata[15:0] & GC_WRITE_MASK;
         if (bus_req_in.wdata[GC_SOFT_RESET])
            flt_s <= 5'h00;
      end else if (go && bus_req_in.addr == OFS_FILTER_CTRL)
         flt_s <= bus_req_in.wdata[4:0];
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   AST_IF_SEL: assert property (
      endec_select_out == ctl_s[GC_ENDEC_SELECT]
      && mii_select_out == !ctl_s[GC_ENDEC_SELECT]) else $error("if sel");
   AST_ENDEC_LOOP: assert property (
      endec_loop_out == ctl_s[GC_ENDEC_LOOP]) else $error("endec loop");
   AST_MDC: assert property (mdc_enable_out == !ctl_s[GC_MDC_OFF])
      else $error("mdc gate");
   AST_LOOP_QUIET: assert property (ctl_s[GC_LOOPBACK] &&
      $past(ctl_s[GC_LOOPBACK]) |-> phy_tx_out == '0) else $error("tx leak");
   AST_ABRUPT: assert property (ctl_s[GC_ABRUPT_HALT] |->
      !tx_run_out && !rx_run_out) else $error("abrupt halt");
   AST_START_OK: assert property (tx_start_ok_out |-> tx_run_out &&
      (!rx_busy_in || ctl_s[GC_DUPLEX] && !ctl_s[GC_LOOPBACK]))
      else $error("tx start");
   AST_REJECT_ALL: assert property (da_valid_in && flt_s == 5'h00 &&
      !mac_sw_reset_out && !bus_req_in.wr |=> accept_valid_out && !accept_out)
      else $error("reject all");
   AST_BCAST: assert property (da_valid_in && &da_in &&
      flt_s[AF_ALL_ONES] && !mac_sw_reset_out && !bus_req_in.wr |=> accept_out)
      else $error("broadcast");
   AST_IRQ: assert property (missed_wrap_in && ctl_s[GC_WRAP_IRQ_EN] &&
      !mac_sw_reset_out && !bus_req_in.wr |=> missed_wrap_irq_out)
      else $error("wrap irq");
   AST_SRST_LEN: assert property ($rose(mac_sw_reset_out) |->
      mac_sw_reset_out[*4] ##1 !mac_sw_reset_out) else $error("srst len");
   cover property (accept_valid_out && accept_out);
   cover property ($fell(mac_sw_reset_out));
   cover property (missed_wrap_irq_out);
endmodule

bind macgc_top macgc_top_chk u_chk (.ref_clk_in, .sys_rst_in, .bus_req_in,
   .rx_busy_in, .missed_wrap_in, .da_valid_in, .da_in, .phy_tx_out,
   .tx_run_out, .rx_run_out, .tx_start_ok_out, .mac_sw_reset_out,
   .missed_wrap_irq_out, .accept_out, .accept_valid_out, .endec_select_out,
   .mii_select_out, .endec_loop_out, .mdc_enable_out);

// ### bench/tb_mac_global_control_and_address_filter.sv
module tb_mac_global_control_and_address_filter;
   timeunit 1ns;
   timeprecision 1ps;
   import macgc_pkg::*;
   logic           ref_clk_in, sys_rst_in, tx_busy_in, rx_busy_in;
   logic           missed_wrap_in, da_valid_in, endec_link_in, link_up;
   logic [47:0]    da_in;
   logic [31:0]    bus_rdata_out, v;
   macgc_bus_req_t bus_req_in;
   macgc_nibble_t  core_tx_in, phy_rx_in, core_rx_out, phy_tx_out;
   logic           tx_run_out, rx_run_out, tx_start_ok_out, mac_sw_reset_out;
   logic           missed_wrap_irq_out, accept_out, accept_valid_out;
   logic           endec_select_out, mii_select_out, endec_loop_out;
   logic           mdc_enable_out;
   int             failures = 0, check_count = 0;
   macgc_top uut (.ref_clk_in, .sys_rst_in, .clk_en_in(1'b1), .bus_req_in,
      .bus_rdata_out, .tx_busy_in, .rx_busy_in, .core_tx_in, .missed_wrap_in,
      .tx_run_out, .rx_run_out, .tx_start_ok_out, .core_rx_out,
      .mac_sw_reset_out, .missed_wrap_irq_out, .da_valid_in, .da_in,
      .accept_out, .accept_valid_out, .phy_rx_in, .endec_link_in, .phy_tx_out,
      .endec_select_out, .mii_select_out, .endec_loop_out, .mdc_enable_out);
   macgc_phy_model phy (.ref_clk_in, .link_up_in(link_up),
      .phy_tx_in(phy_tx_out), .phy_rx_out(phy_rx_in),
      .endec_link_out(endec_link_in));
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk_in);
      bus_req_in <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk_in);
      bus_req_in <= '0;
      #1 v = bus_rdata_out;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(v, exp);
   endtask
   task automatic flt(input logic [4:0] f, input logic [47:0] a,
                      input logic e);
      wr(OFS_FILTER_CTRL, {27'h0000000, f});
      @(posedge ref_clk_in);
      da_valid_in <= 1'b1;
      da_in       <= a;
      @(posedge ref_clk_in);
      da_valid_in <= 1'b0;
      #1 check(accept_valid_out, 1'b1);
      check(accept_out, e);
   endtask
   task automatic miss(input logic e);
      @(posedge ref_clk_in);
      missed_wrap_in <= 1'b1;
      @(posedge ref_clk_in);
      missed_wrap_in <= 1'b0;
      #1 check(missed_wrap_irq_out, e);
   endtask
   task automatic t_regs;
      rdc(OFS_GLOBAL_CTRL, 32'h00000000);
      rdc(OFS_ENTRY_EN, 32'h00000000);
      wr(OFS_FILTER_CTRL, 32'hFFFFFFFF);
      rdc(OFS_FILTER_CTRL, 32'h0000001F);
      wr(OFS_GLOBAL_CTRL, 32'hFFFFFFFB);
      check({tx_run_out, rx_run_out}, 2'b00);
      check({endec_select_out, mii_select_out}, 2'b10);
      check(endec_loop_out, 1'b1);
      check(mdc_enable_out, 1'b0);
      rdc(OFS_GLOBAL_CTRL, 32'h000030DB);
      rdc(16'hA100, 32'h00000000);
      wr(OFS_GLOBAL_CTRL, 32'h00000000);
      link_up <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      rdc(OFS_GLOBAL_CTRL, 32'h00008000);
      link_up <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
   endtask
   task automatic t_filter;
      flt(5'h00, '1, 1'b0);
      flt(5'h01, 48'h001122334455, 1'b1);
      flt(5'h01, 48'h011122334455, 1'b0);
      flt(5'h02, 48'h011122334455, 1'b1);
      flt(5'h02, '1, 1'b0);
      flt(5'h04, '1, 1'b1);
      flt(5'h07, 48'hAABBCCDDEEF0, 1'b1);
      wr(16'h9104, 32'h0000AABB);
      wr(16'h9108, 32'hCCDDEEF0);
      flt(5'h10, 48'hAABBCCDDEEF0, 1'b0);
      wr(OFS_ENTRY_EN, 32'h00000002);
      flt(5'h10, 48'hAABBCCDDEEF0, 1'b1);
      flt(5'h10, 48'hAABBCCDDEEF1, 1'b0);
      flt(5'h18, 48'hAABBCCDDEEF0, 1'b0);
      flt(5'h18, 48'hAABBCCDDEEF1, 1'b1);
      wr(16'h9178, 32'h12345678);
      wr(16'h917C, 32'h9ABC0000);
      wr(OFS_ENTRY_EN, 32'h00100000);
      flt(5'h10, 48'h123456789ABC, 1'b1);
      flt(5'h10, 48'hAABBCCDDEEF0, 1'b0);
   endtask
   task automatic t_srst;
      int n;
      wr(OFS_GLOBAL_CTRL, 32'h00000080);
      wr(OFS_GLOBAL_CTRL, 32'h00000004);
      check({mac_sw_reset_out, endec_loop_out}, 2'b10);
      rdc(OFS_GLOBAL_CTRL, 32'h00000004);
      for (n = 0; n < 10 && v[GC_SOFT_RESET] !== 1'b0; n++)
         bus(1'b0, OFS_GLOBAL_CTRL, 32'h00000000);
      if (n == 10) begin
         failures++;
         report_and_stop;
      end
      check(v, 32'h00000000);
      rdc(OFS_FILTER_CTRL, 32'h00000000);
      rdc(OFS_ENTRY_EN, 32'h00000000);
   endtask
   task automatic t_missed;
      wr(OFS_GLOBAL_CTRL, 32'h00002000);
      miss(1'b1);
      rdc(OFS_GLOBAL_CTRL, 32'h00002400);
      wr(OFS_GLOBAL_CTRL, 32'h00000400);
      rdc(OFS_GLOBAL_CTRL, 32'h00000000);
      miss(1'b0);
      rdc(OFS_GLOBAL_CTRL, 32'h00000400);
   endtask
   task automatic t_loop;
      wr(OFS_GLOBAL_CTRL, 32'h00000418);
      @(posedge ref_clk_in);
      rx_busy_in <= 1'b1;
      core_tx_in <= '{en: 1'b1, d: 4'hA};
      @(posedge ref_clk_in);
      #1 check(core_rx_out, 5'h1A);
      check(phy_tx_out, 5'h00);
      check(tx_start_ok_out, 1'b0);
      wr(OFS_GLOBAL_CTRL, 32'h00000008);
      check(tx_start_ok_out, 1'b1);
      wr(OFS_GLOBAL_CTRL, 32'h00000000);
      check(tx_start_ok_out, 1'b0);
   endtask
   task automatic t_halt;
      @(posedge ref_clk_in);
      tx_busy_in <= 1'b1;
      rx_busy_in <= 1'b0;
      wr(OFS_GLOBAL_CTRL, 32'h00000001);
      repeat (3) @(posedge ref_clk_in);
      #1 check({tx_run_out, rx_run_out}, 2'b10);
      @(posedge ref_clk_in);
      tx_busy_in <= 1'b0;
      rx_busy_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      #1 check({tx_run_out, rx_run_out}, 2'b00);
      wr(OFS_GLOBAL_CTRL, 32'h00000000);
      repeat (2) @(posedge ref_clk_in);
      #1 check({tx_run_out, rx_run_out}, 2'b11);
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      {sys_rst_in, tx_busy_in, rx_busy_in, missed_wrap_in} = 4'b1000;
      {da_valid_in, link_up, da_in, v} = '0;
      bus_req_in = '0;
      core_tx_in = '0;
      repeat (10) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      t_regs;
      t_filter;
      t_srst;
      t_missed;
      t_loop;
      t_halt;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      failures++;
      report_and_stop;
   end
endmodule

// ### rtl/macgc_pkg.sv
package macgc_pkg;

   // ---------------------------------------------------------------------
   // Register map (byte addresses).
   // ---------------------------------------------------------------------
   localparam logic [15:0] OFS_GLOBAL_CTRL = 16'hA000;
   localparam logic [15:0] OFS_FILTER_CTRL = 16'hA004;
   localparam logic [15:0] OFS_ENTRY_EN    = 16'hA028;
   localparam logic [15:0] OFS_CAM_FIRST   = 16'h9100;
   localparam logic [15:0] OFS_CAM_LAST    = 16'h917C;

   // ---------------------------------------------------------------------
   // Global control fields.
   // ---------------------------------------------------------------------
   localparam int GC_GRACEFUL_HALT = 0;
   localparam int GC_ABRUPT_HALT   = 1;
   localparam int GC_SOFT_RESET    = 2;
   localparam int GC_DUPLEX        = 3;
   localparam int GC_LOOPBACK      = 4;
   localparam int GC_ENDEC_SELECT  = 6;
   localparam int GC_ENDEC_LOOP    = 7;
   localparam int GC_MISSED_WRAP   = 10;
   localparam int GC_MDC_OFF       = 12;
   localparam int GC_WRAP_IRQ_EN   = 13;
   localparam int GC_LINK_STATUS   = 15;
   localparam logic [15:0] GC_WRITE_MASK = 16'h30DF;
   localparam logic [15:0] GC_RESET_VAL  = 16'h0000;

   // ---------------------------------------------------------------------
   // Address filter control fields.
   // ---------------------------------------------------------------------
   localparam int AF_UNICAST   = 0;
   localparam int AF_MULTICAST = 1;
   localparam int AF_ALL_ONES  = 2;
   localparam int AF_INVERT    = 3;
   localparam int AF_COMPARE   = 4;
   localparam logic [4:0]  AF_RESET_VAL = 5'h00;
   localparam logic [20:0] EN_RESET_VAL = 21'h000000;

   // ---------------------------------------------------------------------
   // Sizes and timing.
   // ---------------------------------------------------------------------
   localparam int CAM_ENTRIES  = 21;
   localparam int CAM_WORDS    = 32;
   localparam int CLK_NS       = 20;
   localparam int SRST_NS      = 80;
   localparam int SRST_CYCLES  = (SRST_NS + CLK_NS - 1) / CLK_NS;

   // ---------------------------------------------------------------------
   // Carriers.
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } macgc_bus_req_t;

   typedef struct packed {
      logic       en;
      logic [3:0] d;
   } macgc_nibble_t;

   typedef struct packed {
      logic [15:0]                  ctrl;
      logic [4:0]                   filt;
      logic [20:0]                  cam_en;
      logic [CAM_WORDS-1:0][31:0]   cam;
      logic [2:0]                   rst_cnt;
      logic                         tx_halt;
      logic                         rx_halt;
      logic [5:0]                   s1;
      logic [5:0]                   s2;
      logic [5:0]                   s3;
      logic [5:0]                   pin;
      logic [31:0]                  rdata;
      logic                         accept;
      logic                         accept_vld;
      logic                         irq;
      macgc_nibble_t                phy_tx;
      macgc_nibble_t                core_rx;
   } macgc_state_t;

endpackage

// ### rtl/macgc_top.sv
// The strobed register port was decided locally.
module macgc_top (
   // Clock, reset and enable.
   input  wire logic                     ref_clk_in,
   input  wire logic                     sys_rst_in,
   input  wire logic                     clk_en_in,
   // Register port.
   input  wire macgc_pkg::macgc_bus_req_t bus_req_in,
   output logic [31:0]                   bus_rdata_out,
   // MAC core side.
   input  wire logic                     tx_busy_in,
   input  wire logic                     rx_busy_in,
   input  wire macgc_pkg::macgc_nibble_t core_tx_in,
   input  wire logic                     missed_wrap_in,
   output logic                          tx_run_out,
   output logic                          rx_run_out,
   output logic                          tx_start_ok_out,
   output macgc_pkg::macgc_nibble_t      core_rx_out,
   output logic                          mac_sw_reset_out,
   output logic                          missed_wrap_irq_out,
   // Destination address filter.
   input  wire logic                     da_valid_in,
   input  wire logic [47:0]              da_in,
   output logic                          accept_out,
   output logic                          accept_valid_out,
   // PHY or endec side.
   input  wire macgc_pkg::macgc_nibble_t phy_rx_in,
   input  wire logic                     endec_link_in,
   output macgc_pkg::macgc_nibble_t      phy_tx_out,
   output logic                          endec_select_out,
   output logic                          mii_select_out,
   output logic                          endec_loop_out,
   output logic                          mdc_enable_out
);
   import macgc_pkg::*;

   macgc_state_t q;
   macgc_state_t d;

   logic [CAM_ENTRIES-1:0] cam_hit;
   logic                   is_unicast;
   logic                   is_all_ones;
   logic                   is_multicast;
   logic                   duplex_eff;
   logic                   wr_gc;
   logic                   wr_af;
   logic                   wr_en;
   logic                   wr_cam;
   logic [4:0]             cam_idx;
   logic [5:0]             pin_raw;
   logic [5:0]             agree;
   logic [15:0]            gc_read;

   // ----------------------------------------------------------------------
   // CAM entry compare.
   // ----------------------------------------------------------------------
   // Entries are packed back to back, six bytes each, first byte in the
   // top lane of a word.
   for (genvar k = 0; k < CAM_ENTRIES; k++) begin : g_entry
      logic [47:0] entry;
      for (genvar b = 0; b < 6; b++) begin : g_byte
         assign entry[47-8*b -: 8] =
            q.cam[(6*k+b)/4][31-8*((6*k+b)%4) -: 8];
      end
      assign cam_hit[k] = q.cam_en[k] && (entry == da_in);
   end

   // ----------------------------------------------------------------------
   // Address classes.
   // ----------------------------------------------------------------------
   assign is_all_ones  = &da_in;
   assign is_unicast   = ~da_in[40];
   assign is_multicast = da_in[40] && !is_all_ones;

   // ----------------------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------------------
   assign wr_gc  = bus_req_in.wr && (bus_req_in.addr == OFS_GLOBAL_CTRL);
   assign wr_af  = bus_req_in.wr && (bus_req_in.addr == OFS_FILTER_CTRL);
   assign wr_en  = bus_req_in.wr && (bus_req_in.addr == OFS_ENTRY_EN);
   assign wr_cam = bus_req_in.wr && (bus_req_in.addr >= OFS_CAM_FIRST)
                   && (bus_req_in.addr <= OFS_CAM_LAST)
                   && (bus_req_in.addr[1:0] == 2'h0);
   assign cam_idx = bus_req_in.addr[6:2];

   assign pin_raw = {endec_link_in, phy_rx_in};
   // The second and third stages must agree before a pin change counts.
   assign agree   = ~(q.s2 ^ q.s3);

   // Loopback takes priority over the duplex selection.
   assign duplex_eff = q.ctrl[GC_DUPLEX] && !q.ctrl[GC_LOOPBACK];

   always_comb begin
      gc_read = q.ctrl & GC_WRITE_MASK;
      gc_read[GC_MISSED_WRAP] = q.ctrl[GC_MISSED_WRAP];
      gc_read[GC_LINK_STATUS] = q.pin[5];
   end

   // ----------------------------------------------------------------------
   // Next state.
   // ----------------------------------------------------------------------
   always_comb begin
      d = q;

      // Pin synchronisers: stage one feeds stage two only.
      d.s1  = pin_raw;
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.pin = (agree & q.s3) | (~agree & q.pin);

      // Read data stand for one cycle only.
      d.rdata = 32'h0000_0000;
      if (bus_req_in.rd) begin
         case (bus_req_in.addr)
            OFS_GLOBAL_CTRL: d.rdata = {16'h0000, gc_read};
            OFS_FILTER_CTRL: d.rdata = {27'h0000000, q.filt};
            OFS_ENTRY_EN:    d.rdata = {11'h000, q.cam_en};
            default:         d.rdata = 32'h0000_0000;
         endcase
      end

      // Register writes.
      if (wr_gc) begin
         d.ctrl = (bus_req_in.wdata[15:0] & GC_WRITE_MASK)
                  | (q.ctrl & ~GC_WRITE_MASK);
         // The wrap flag is cleared by writing a one to it.
         if (bus_req_in.wdata[GC_MISSED_WRAP]) begin
            d.ctrl[GC_MISSED_WRAP] = 1'b0;
         end
      end
      if (wr_af) begin
         d.filt = bus_req_in.wdata[4:0];
      end
      if (wr_en) begin
         d.cam_en = bus_req_in.wdata[20:0];
      end
      if (wr_cam) begin
         d.cam[cam_idx] = bus_req_in.wdata;
      end

      // A wrap in the same cycle as a clear still sets the flag.
      if (missed_wrap_in) begin
         d.ctrl[GC_MISSED_WRAP] = 1'b1;
      end
      d.irq = missed_wrap_in && q.ctrl[GC_WRAP_IRQ_EN];

      // Halt handling: abrupt wins, graceful waits for the frame to end.
      if (q.ctrl[GC_ABRUPT_HALT]) begin
         d.tx_halt = 1'b1;
         d.rx_halt = 1'b1;
      end else if (q.ctrl[GC_GRACEFUL_HALT]) begin
         d.tx_halt = q.tx_halt || !tx_busy_in;
         d.rx_halt = q.rx_halt || !rx_busy_in;
      end else begin
         d.tx_halt = 1'b0;
         d.rx_halt = 1'b0;
      end

      // Transmit path: loopback keeps the PHY side quiet.
      if (q.ctrl[GC_LOOPBACK]) begin
         d.phy_tx  = '0;
         d.core_rx = core_tx_in;
      end else begin
         d.phy_tx  = core_tx_in;
         d.core_rx = q.pin[4:0];
      end

      // Destination filter decision, one cycle after the address.
      d.accept_vld = da_valid_in;
      d.accept     = 1'b0;
      if (da_valid_in) begin
         d.accept = (is_unicast   && q.filt[AF_UNICAST])
                 || (is_multicast && q.filt[AF_MULTICAST])
                 || (is_all_ones  && q.filt[AF_ALL_ONES])
                 || (q.filt[AF_COMPARE]
                     && ((|cam_hit) ^ q.filt[AF_INVERT]));
      end

      // Software reset: start, hold, then clear the request bit.
      if (q.rst_cnt != 3'h0) begin
         d.rst_cnt = q.rst_cnt - 3'h1;
         d.ctrl    = GC_RESET_VAL;
         d.filt    = AF_RESET_VAL;
         d.cam_en  = EN_RESET_VAL;
         d.tx_halt = 1'b0;
         d.rx_halt = 1'b0;
         d.irq     = 1'b0;
         d.accept  = 1'b0;
         d.accept_vld = 1'b0;
         d.ctrl[GC_SOFT_RESET] = (q.rst_cnt != 3'h1);
      end else if (wr_gc && bus_req_in.wdata[GC_SOFT_RESET]) begin
         d.rst_cnt = 3'(SRST_CYCLES);
         d.ctrl    = GC_RESET_VAL;
         d.ctrl[GC_SOFT_RESET] = 1'b1;
         d.filt    = AF_RESET_VAL;
         d.cam_en  = EN_RESET_VAL;
      end
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         q <= '0;
      end else if (clk_en_in) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------------
   assign bus_rdata_out       = q.rdata;
   assign tx_run_out          = !q.tx_halt && !q.ctrl[GC_ABRUPT_HALT];
   assign rx_run_out          = !q.rx_halt && !q.ctrl[GC_ABRUPT_HALT];
   assign tx_start_ok_out     = tx_run_out
                                && (duplex_eff || !rx_busy_in);
   assign core_rx_out         = q.core_rx;
   assign phy_tx_out          = q.phy_tx;
   assign mac_sw_reset_out    = q.ctrl[GC_SOFT_RESET];
   assign missed_wrap_irq_out = q.irq;
   assign accept_out          = q.accept;
   assign accept_valid_out    = q.accept_vld;
   assign endec_select_out    = q.ctrl[GC_ENDEC_SELECT];
   assign mii_select_out      = !q.ctrl[GC_ENDEC_SELECT];
   assign endec_loop_out      = q.ctrl[GC_ENDEC_LOOP];
   assign mdc_enable_out      = !q.ctrl[GC_MDC_OFF];

endmodule
